// [hw/isp_status_port.sv]
// interrupt status port with switch or programmable address decode
`timescale 1ns/100ps
module sisp_status_port (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // host i/o bus
   input wire logic [sisp_pkg::ADDR_W-1:0] bus_addr,
   input wire logic bus_rd,
   input wire logic bus_wr,
   output logic [7:0] status_data,
   output logic status_data_oe,
   // straps
   input wire logic [sisp_pkg::SW_W-1:0] base_switch_open,
   input wire logic address_mode_selector,
   // programmable decode option
   input wire logic prog_status_sel,
   input wire logic [sisp_pkg::NUM_CHAN-1:0] prog_chan_sel,
   // uart side
   input wire logic [sisp_pkg::NUM_CHAN-1:0] uart_irq,
   output logic [sisp_pkg::NUM_CHAN-1:0] uart_cs,
   input wire sisp_pkg::sisp_dte_out_t [sisp_pkg::NUM_CHAN-1:0] uart_line_out,
   output sisp_pkg::sisp_dte_in_t [sisp_pkg::NUM_CHAN-1:0] uart_line_in,
   // connector side
   output sisp_pkg::sisp_dte_out_t [sisp_pkg::NUM_CHAN-1:0] line_out,
   input wire sisp_pkg::sisp_dte_in_t [sisp_pkg::NUM_CHAN-1:0] line_in
);

   localparam int NC = sisp_pkg::NUM_CHAN;
   localparam int LW = $bits(sisp_pkg::sisp_dte_in_t);
   localparam int BW = $bits(sisp_pkg::sisp_bus_req_t);
   localparam int SW = sisp_pkg::SW_W;
   localparam int AW = sisp_pkg::ADDR_W;
   localparam int SYNC_W = BW + 1 + NC + NC + NC * LW + SW + 1;

   // ==========================================================
   // synchronise every pin input except ref_clk, rst and uart_line_out
   sisp_pkg::sisp_bus_req_t bus_s;
   logic prog_status_s;
   logic [NC-1:0] prog_chan_s;
   logic [NC-1:0] irq_s;
   sisp_pkg::sisp_dte_in_t [NC-1:0] line_in_s;
   logic [SW-1:0] sw_open_s;
   logic prog_mode_s;

   sisp_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in({bus_rd, bus_wr, bus_addr, prog_status_sel, prog_chan_sel,
                 uart_irq, line_in, base_switch_open,
                 address_mode_selector}),
      .sync_out({bus_s, prog_status_s, prog_chan_s, irq_s, line_in_s,
                 sw_open_s, prog_mode_s})
   );

   // ==========================================================
   // address decode
   function automatic logic [NC-1:0] chan_onehot(input logic [2:0] win);
      chan_onehot = '0;
      chan_onehot[win] = 1'b1;
   endfunction

   // open switch reads as a one, closed as a zero
   wire [SW-1:0] base_bits = sw_open_s; // R8
   wire [2:0] win_idx = bus_s.addr[sisp_pkg::BASE_LSB-1:sisp_pkg::WIN_LSB];
   wire [2:0] win_off = bus_s.addr[sisp_pkg::WIN_LSB-1:0];
   // 64-location block aligned on a 64-byte boundary
   wire block_hit = (bus_s.addr[AW-1:sisp_pkg::BASE_LSB+SW] == '0) &&
                    (bus_s.addr[sisp_pkg::BASE_LSB+SW-1:sisp_pkg::BASE_LSB]
                     == base_bits); // R7
   wire sw_status_hit = block_hit &&
                        (win_off == sisp_pkg::STATUS_OFFSET); // R3
   // offset seven steals the uart's own register
   wire [NC-1:0] sw_chan_sel = (block_hit && !sw_status_hit) ?
                               chan_onehot(win_idx) : '0; // R7 R10
   // programmable position overrides the switches entirely
   wire status_hit = prog_mode_s ? prog_status_s : sw_status_hit; // R5 R9
   wire [NC-1:0] chan_sel = prog_mode_s ? prog_chan_s : sw_chan_sel; // R9
   wire access = bus_s.rd || bus_s.wr;
   // writes to the status location fall on the floor
   wire status_read = bus_s.rd && status_hit; // R10

   // ==========================================================
   // registers
   logic [7:0] status_q;
   logic [7:0] status_data_q;
   logic status_oe_q;
   logic [NC-1:0] uart_cs_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_q <= sisp_pkg::STATUS_RESET;
         status_data_q <= '0;
         status_oe_q <= 1'b0;
         uart_cs_q <= '0;
      end else begin
         status_q <= irq_s; // R1 R2
         // same byte whichever window asked for it
         status_data_q <= status_read ? status_q : '0; // R4
         status_oe_q <= status_read;
         uart_cs_q <= access ? chan_sel : '0;
      end
   end

   assign status_data = status_data_q;
   assign status_data_oe = status_oe_q;
   assign uart_cs = uart_cs_q;

   // ==========================================================
   // terminal-equipment pin directions, one flop each way
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++) begin : g_chan
         sisp_pkg::sisp_dte_out_t out_q;
         sisp_pkg::sisp_dte_in_t in_q;
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               out_q <= '0;
               in_q <= '0;
            end else begin
               out_q <= uart_line_out[gi]; // R6
               in_q <= line_in_s[gi]; // R6
            end
         end
         assign line_out[gi] = out_q;
         assign uart_line_in[gi] = in_q;
      end
   endgenerate

   // ==========================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   irq_bit_map_a: assert property ( // R2
      !$past(rst) |-> status_q == $past(irq_s))
      else $error("status bit does not follow its channel interrupt");

   status_read_value_a: assert property ( // R1
      status_oe_q |-> status_data_q == $past(status_q))
      else $error("status read returns wrong byte");

   idle_data_zero_a: assert property ( // R4
      !status_oe_q |-> status_data_q == 8'h00)
      else $error("status data not zero while idle");

   switch_offset_read_a: assert property ( // R3
      (!prog_mode_s && bus_s.rd && block_hit &&
       win_off == sisp_pkg::STATUS_OFFSET)
      |=> status_oe_q && uart_cs_q == '0)
      else $error("offset seven read not answered by status byte");

   offset_write_drop_a: assert property ( // R10
      (!prog_mode_s && bus_s.wr && !bus_s.rd && sw_status_hit)
      |=> !status_oe_q && uart_cs_q == '0)
      else $error("write at status offset reached something");

   window_select_a: assert property ( // R7
      (!prog_mode_s && access && block_hit &&
       win_off != sisp_pkg::STATUS_OFFSET)
      |=> uart_cs_q == (8'h01 << $past(win_idx)))
      else $error("wrong channel window selected");

   prog_decode_a: assert property ( // R9
      (prog_mode_s && access) |=> uart_cs_q == $past(prog_chan_s))
      else $error("programmable decode not followed");

   prog_status_a: assert property ( // R5
      (prog_mode_s && bus_s.rd) |=> status_oe_q == $past(prog_status_s))
      else $error("programmable status select not followed");

   line_dir_a: assert property ( // R6
      !$past(rst) |-> line_out[0] == $past(uart_line_out[0]) &&
      uart_line_in[0] == $past(line_in_s[0]))
      else $error("line direction mismatch on channel one");

   switch_polarity_a: assert property ( // R8
      (!prog_mode_s && bus_s.addr[sisp_pkg::BASE_LSB+SW-1:sisp_pkg::BASE_LSB]
       != sw_open_s) |-> !block_hit)
      else $error("base decode ignores switch levels");

endmodule // sisp_status_port

// [pkg/isp_pkg.sv]
// constants and carrier types for the shared interrupt status port
// Notes on behaviour
// [R1] An 8-bit read-only status byte shows a set bit while a channel's interrupt is pending, clear otherwise.
// [R2] Channel one's interrupt sits at bit 0, channel two's at bit 1, up to channel eight at bit 7.
// [R3] With the address mode selector in switch position the status byte decodes at offset seven of every channel window.
// [R4] All eight decoded copies of the status byte return the same value.
// [R5] In programmable position the status byte answers wherever the programmable decode option points.
// [R6] Each channel is terminal equipment: TD, RTS, DTR are outputs; RD, CTS, DSR, DCD, RI are inputs.
// [R7] In switch mode the card takes 64 aligned locations, channel n at base plus eight times (n minus one).
// [R8] A closed base switch gives a zero address bit and an open switch gives a one.
// [R9] Programmable position hands all channel and status decoding to the programmable decode option.
// [R10] In switch mode offset seven reads return the status byte instead of the UART, and writes there go nowhere.
package sisp_pkg;

   // ==========================================================
   // sizes and map
   localparam int NUM_CHAN = 8;
   localparam int ADDR_W = 16;
   localparam int BASE_LSB = 6;
   localparam int SW_W = 7;
   localparam int WIN_LSB = 3;
   localparam logic [2:0] STATUS_OFFSET = 3'h7;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int SYNC_STAGES = 2;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic rd;
      logic cts;
      logic dsr;
      logic dcd;
      logic ri;
   } sisp_dte_in_t;

   typedef struct packed {
      logic td;
      logic rts;
      logic dtr;
   } sisp_dte_out_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
   } sisp_bus_req_t;

endpackage

// [hw/isp_sync.sv]
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module sisp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // first stage feeds only the second stage
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // sisp_sync

// [tb/isp_host_model.sv]
// host-side i/o bus model driving the adapter's strobes
`timescale 1ns/100ps
module sisp_host_model (
   // clock
   input wire logic ref_clk,
   // bus toward the adapter
   output logic [sisp_pkg::ADDR_W-1:0] bus_addr,
   output logic bus_rd,
   output logic bus_wr,
   input wire logic [7:0] status_data,
   input wire logic status_data_oe
);
   // ==========================================================
   // idle bus
   initial begin
      bus_addr = 16'h0000;
      bus_rd = 1'h0;
      bus_wr = 1'h0;
   end

   // ==========================================================
   // one access, held past the two-edge sync latency
   task automatic io_access(input logic [sisp_pkg::ADDR_W-1:0] addr,
      input logic wr, output logic [7:0] data, output logic oe);
      @(negedge ref_clk);
      bus_addr = addr;
      bus_rd = !wr;
      bus_wr = wr;
      repeat (6) @(negedge ref_clk);
      data = status_data;
      oe = status_data_oe;
      bus_rd = 1'h0;
      bus_wr = 1'h0;
      // released address is driven to its complement: never leave a stale copy
      bus_addr = ~addr;
   endtask
endmodule // sisp_host_model

// [tb/shared_irq_status_port_test.sv]
// self-checking bench for the shared interrupt status port
`timescale 1ns/100ps
module shared_irq_status_port_test;
   // ==========================================================
   // pins
   logic ref_clk;
   logic rst;
   logic [15:0] bus_addr;
   logic bus_rd;
   logic bus_wr;
   logic [7:0] status_data;
   logic status_data_oe;
   logic [6:0] base_switch_open;
   logic address_mode_selector;
   logic prog_status_sel;
   logic [7:0] prog_chan_sel;
   logic [7:0] uart_irq;
   logic [7:0] uart_cs;
   sisp_pkg::sisp_dte_out_t [7:0] uart_line_out;
   sisp_pkg::sisp_dte_in_t [7:0] uart_line_in;
   sisp_pkg::sisp_dte_out_t [7:0] line_out;
   sisp_pkg::sisp_dte_in_t [7:0] line_in;
   int mismatches;
   int total_checks;
   logic [7:0] rd_data;
   logic rd_oe;
   logic [15:0] r_addr;
   logic r_wr;
   logic [7:0] e_d;
   logic e_oe;
   logic [7:0] e_cs;
   // mode, addr, wr, prog status, prog chans, irq, data, oe, cs
   logic [51:0] rows [13] = '{
      {1'h0,16'h0287,1'h0,1'h0,8'h00,8'h02,8'h02,1'h1,8'h00},
      {1'h0,16'h02bf,1'h0,1'h0,8'h00,8'ha5,8'ha5,1'h1,8'h00},
      {1'h0,16'h028f,1'h0,1'h0,8'h00,8'h80,8'h80,1'h1,8'h00},
      {1'h0,16'h0280,1'h0,1'h0,8'h00,8'hff,8'h00,1'h0,8'h01},
      {1'h0,16'h02b8,1'h0,1'h0,8'h00,8'h00,8'h00,1'h0,8'h80},
      {1'h0,16'h0297,1'h1,1'h0,8'h00,8'hff,8'h00,1'h0,8'h00},
      {1'h0,16'h0299,1'h1,1'h0,8'h00,8'h00,8'h00,1'h0,8'h08},
      {1'h0,16'h02c7,1'h0,1'h0,8'h00,8'hff,8'h00,1'h0,8'h00},
      {1'h0,16'h0247,1'h0,1'h1,8'hff,8'hff,8'h00,1'h0,8'h00},
      {1'h1,16'h0287,1'h0,1'h0,8'h00,8'hff,8'h00,1'h0,8'h00},
      {1'h1,16'h1234,1'h0,1'h1,8'h00,8'h5a,8'h5a,1'h1,8'h00},
      {1'h1,16'h0300,1'h0,1'h0,8'h04,8'h00,8'h00,1'h0,8'h04},
      {1'h1,16'h0300,1'h1,1'h1,8'h00,8'h33,8'h00,1'h0,8'h00}};

   sisp_status_port uut (.ref_clk(ref_clk), .rst(rst),
      .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
      .status_data(status_data), .status_data_oe(status_data_oe),
      .base_switch_open(base_switch_open),
      .address_mode_selector(address_mode_selector),
      .prog_status_sel(prog_status_sel), .prog_chan_sel(prog_chan_sel),
      .uart_irq(uart_irq), .uart_cs(uart_cs),
      .uart_line_out(uart_line_out), .uart_line_in(uart_line_in),
      .line_out(line_out), .line_in(line_in));
   sisp_host_model host (.ref_clk(ref_clk), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .status_data(status_data),
      .status_data_oe(status_data_oe));

   // ==========================================================
   // helpers
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end

   // ==========================================================
   // sequence
   initial begin
      mismatches = 0;
      total_checks = 0;
      rst = 1'h1;
      base_switch_open = 7'h0a;
      {address_mode_selector, prog_status_sel, prog_chan_sel} = 10'h000;
      uart_irq = 8'hff;
      uart_line_out = 24'h000000;
      line_in = 40'h0000000000;
      repeat (12) @(negedge ref_clk);
      check({status_data_oe, status_data, uart_cs}, 17'h00000);
      rst = 1'h0;
      $display("reset done");
      foreach (rows[i]) begin
         {address_mode_selector, r_addr, r_wr, prog_status_sel,
            prog_chan_sel, uart_irq, e_d, e_oe, e_cs} = rows[i];
         host.io_access(r_addr, r_wr, rd_data, rd_oe);
         check(rd_data, e_d);
         check(rd_oe, e_oe);
         check(uart_cs, e_cs);
      end
      $display("table done");
      // base moved by the switches: closed gives zero
      {address_mode_selector, prog_status_sel, prog_chan_sel} = 10'h000;
      base_switch_open = 7'h56;
      uart_irq = 8'h3c;
      host.io_access(16'h15bf, 1'h0, rd_data, rd_oe);
      check({rd_oe, rd_data}, 9'h13c);
      host.io_access(16'h02bf, 1'h0, rd_data, rd_oe);
      check(rd_oe, 1'h0);
      // every window's offset seven shows the same byte
      for (int w = 0; w < 8; w++) begin
         host.io_access(16'h1587 + 16'(w * 8), 1'h0, rd_data, rd_oe);
         check({rd_oe, rd_data}, 9'h13c);
      end
      $display("switch test done");
      // terminal-side line directions
      line_in = 40'h5a3c96e10f;
      uart_line_out = 24'ha5c30f;
      repeat (5) @(negedge ref_clk);
      check(uart_line_in, line_in);
      check(line_out, uart_line_out);
      $display("line test done");
      // reset in mid-access clears the status drive
      fork
         host.io_access(16'h15bf, 1'h0, rd_data, rd_oe);
         begin
            repeat (2) @(negedge ref_clk);
            rst = 1'h1;
         end
      join
      check({rd_oe, rd_data}, {1'h0, sisp_pkg::STATUS_RESET});
      rst = 1'h0;
      $display("mid reset done");
      complete_run();
   end
endmodule // shared_irq_status_port_test
